/* dv/nts_node_model.sv */
// Behavioural model of the far-side network nodes that deliver packets to the time unit.
`timescale 1ns/1ps
`default_nettype none
module nts_node_model (
   input  wire logic        core_clk,
   output var  logic        rx_valid,
   output var  logic [3:0]  rx_src_id,
   output var  logic [15:0] rx_time,
   output var  logic        rx_init_setting
);
   // ----------------------------------------------------------------------------
   // Packet delivery
   // ----------------------------------------------------------------------------
   // Idle fields carry junk, so a stale value is never taken for a fresh one.
   initial begin
      rx_valid        = 1'b0;
      rx_src_id       = 4'hf;
      rx_time         = 16'h5a5a;
      rx_init_setting = 1'b0;
   end

   // One packet for one cycle; callers may pass ids out of range and name one master only.
   task automatic send(input logic [3:0] src, input logic [15:0] t, input logic init);
      rx_valid        = ~init;
      rx_init_setting = init;
      rx_src_id       = src;
      rx_time         = t;
      @(posedge core_clk);
      #1;
      rx_valid        = 1'b0;
      rx_init_setting = 1'b0;
      rx_src_id       = ~src;
      rx_time         = ~t;
   endtask : send
endmodule : nts_node_model
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench of the network time unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ----------------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------------
   logic        core_clk, rst, page_size_sel, flag_sel_configured, carry_sel_configured;
   logic        carry_style_wr, carry_style_val, rx_valid, rx_init_setting, tx_stamp_req;
   logic        ext_trig_n, status_clear, tx_stamp_valid, rx_stamp_valid, time_unlocked;
   logic        time_unlocked_flag, carry_output_style, time_carry_out_n;
   logic [2:0]  time_prescale_sel;
   logic [3:0]  own_node_id, master_node_id, transmit_trigger_sel, flag_output_select;
   logic [3:0]  carry_bit_sel, rx_src_id;
   logic [15:0] rx_time, network_time, tx_stamp, rx_stamp;
   int          n_fail;
   int          check_count;

   // Free-running 25 MHz clock.
   always #20 core_clk = ~core_clk;

   nts_time_unit uut (.core_clk, .rst, .own_node_id, .master_node_id, .time_prescale_sel, .page_size_sel,
      .transmit_trigger_sel, .flag_output_select, .flag_sel_configured, .carry_bit_sel, .carry_sel_configured,
      .carry_style_wr, .carry_style_val, .rx_valid, .rx_src_id, .rx_time, .rx_init_setting, .tx_stamp_req,
      .ext_trig_n, .status_clear, .network_time, .tx_stamp, .tx_stamp_valid, .rx_stamp, .rx_stamp_valid,
      .time_unlocked, .time_unlocked_flag, .carry_output_style, .time_carry_out_n);

   nts_node_model node (.core_clk, .rx_valid, .rx_src_id, .rx_time, .rx_init_setting);

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   task automatic end_sim();
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk_t(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_t

   task automatic chk_b(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: bit %b, expected %b", $time, got, exp);
      end
   endtask : chk_b

   // Inputs always move one nanosecond after the rising edge.
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
      end
   endtask : cyc

   // Bounded wait for the counter to move; a stall ends the run.
   task automatic wait_change(output int cycles);
      logic [15:0] prev;
      prev = network_time;
      cycles = 0;
      while (network_time === prev) begin
         cyc(1);
         cycles++;
         if (cycles > 9000) begin
            n_fail++;
            $display("ERROR %0t: counter stalled", $time);
            end_sim();
         end
      end
   endtask : wait_change

   // Reset with this node as id 3 and node 5 as time master; all nodes share one prescale.
   task automatic do_reset(input logic [2:0] sel);
      rst = 1'b1;
      own_node_id = 4'h3;
      master_node_id = 4'h5;
      time_prescale_sel = sel;
      page_size_sel = 1'b1;
      transmit_trigger_sel = 4'h0;
      flag_output_select = 4'h4;
      flag_sel_configured = 1'b0;
      carry_bit_sel = 4'h0;
      carry_sel_configured = 1'b0;
      carry_style_wr = 1'b0;
      carry_style_val = 1'b1;
      tx_stamp_req = 1'b0;
      ext_trig_n = 1'b1;
      status_clear = 1'b0;
      cyc(16);
      rst = 1'b0;
      cyc(1);
   endtask : do_reset

   task automatic stamp(input logic [15:0] exp);
      tx_stamp_req = 1'b1;
      cyc(1);
      tx_stamp_req = 1'b0;
      chk_b(tx_stamp_valid, 1'b1);
      chk_t(tx_stamp, exp);
      cyc(1);
      chk_b(tx_stamp_valid, 1'b0);
   endtask : stamp

   task automatic hold_high(input int n);
      repeat (n) begin
         cyc(1);
         chk_b(time_carry_out_n, 1'b1);
      end
   endtask : hold_high

   // Clock style follows the inverse of the selected bit one cycle late.
   task automatic clock_check(input int b, input int n);
      logic [15:0] prev;
      repeat (n) begin
         prev = network_time;
         cyc(1);
         chk_b(time_carry_out_n, ~prev[b]);
      end
   endtask : clock_check

   // ----------------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------------
   task automatic sc_reset();
      do_reset(3'h7);
      chk_t(network_time, 16'h0000);
      chk_b(time_unlocked, 1'b1);
      chk_b(carry_output_style, 1'b1);
      chk_b(time_carry_out_n, 1'b1);
   endtask : sc_reset

   task automatic sc_prescale();
      logic [15:0] prev;
      int          n;
      do_reset(3'h0);
      for (int s = 0; s < 3; s++) begin
         time_prescale_sel = 3'(s);
         wait_change(n);
         prev = network_time;
         wait_change(n);
         chk_t(16'(n), 16'h0020 << s);
         chk_t(network_time, prev + 16'h0001);
      end
      node.send(4'h5, 16'hffff, 1'b0);
      wait_change(n);
      chk_t(network_time, 16'h0000);
   endtask : sc_prescale

   // A far value first, then values at +2, -2 and 0 from the local count, then one at +3.
   task automatic sc_lock();
      do_reset(3'h7);
      node.send(4'h5, 16'h1234, 1'b0);
      chk_t(network_time, 16'h1234);
      chk_b(rx_stamp_valid, 1'b0);
      cyc(1);
      node.send(4'h5, network_time + 16'h0002, 1'b0);
      cyc(1);
      node.send(4'h5, network_time - 16'h0002, 1'b0);
      cyc(2);
      chk_b(time_unlocked_flag, 1'b1);
      node.send(4'h5, network_time, 1'b0);
      cyc(2);
      chk_b(time_unlocked_flag, 1'b0);
      chk_b(time_unlocked, 1'b1);
      status_clear = 1'b1;
      cyc(1);
      status_clear = 1'b0;
      cyc(1);
      chk_b(time_unlocked, 1'b0);
      node.send(4'h5, network_time + 16'h0003, 1'b0);
      cyc(2);
      chk_b(time_unlocked_flag, 1'b1);
      chk_b(time_unlocked, 1'b1);
   endtask : sc_lock

   task automatic sc_refuse();
      do_reset(3'h7);
      node.send(4'h2, 16'h4321, 1'b0);
      chk_b(rx_stamp_valid, 1'b1);
      chk_t(rx_stamp, 16'h4321);
      chk_t(network_time, 16'h0000);
      page_size_sel = 1'b0;
      master_node_id = 4'h9;
      cyc(1);
      node.send(4'h9, 16'h7777, 1'b0);
      cyc(1);
      chk_t(network_time, 16'h0000);
      master_node_id = 4'h3;
      node.send(4'h3, 16'h7777, 1'b0);
      cyc(2);
      chk_t(network_time, 16'h0000);
      chk_b(time_unlocked, 1'b0);
   endtask : sc_refuse

   // The trigger latch must survive a later resync that moves the counter.
   task automatic sc_stamp();
      do_reset(3'h7);
      node.send(4'h5, 16'h0abc, 1'b0);
      transmit_trigger_sel = 4'h6;
      ext_trig_n = 1'b0;
      cyc(6);
      ext_trig_n = 1'b1;
      node.send(4'h5, 16'h0def, 1'b0);
      stamp(16'h0abc);
      transmit_trigger_sel = 4'h0;
      stamp(16'h0def);
   endtask : sc_stamp

   task automatic sc_carry_init();
      int n;
      int lows;
      do_reset(3'h0);
      master_node_id = 4'h0;
      flag_output_select = 4'h5;
      carry_sel_configured = 1'b1;
      node.send(4'h0, 16'h0000, 1'b1);
      hold_high(100);
      flag_sel_configured = 1'b1;
      for (int b = 0; b < 2; b++) begin
         carry_bit_sel = 4'(b);
         cyc(2);
         clock_check(b, 200);
      end
      carry_bit_sel = 4'h0;
      carry_style_val = 1'b0;
      carry_style_wr = 1'b1;
      cyc(1);
      carry_style_wr = 1'b0;
      chk_b(carry_output_style, 1'b0);
      wait_change(n);
      cyc(3);
      lows = 0;
      repeat (320) begin
         cyc(1);
         lows += (time_carry_out_n === 1'b0) ? 1 : 0;
      end
      chk_t(16'(lows), 16'h0005);
   endtask : sc_carry_init

   task automatic sc_carry_master();
      do_reset(3'h0);
      flag_output_select = 4'h5;
      flag_sel_configured = 1'b1;
      carry_sel_configured = 1'b1;
      node.send(4'h2, 16'h0000, 1'b0);
      cyc(1);
      node.send(4'h0, 16'h0000, 1'b1);
      hold_high(100);
      node.send(4'h5, 16'h0000, 1'b0);
      cyc(2);
      clock_check(0, 100);
   endtask : sc_carry_master

   initial begin
      core_clk = 1'b0;
      n_fail = 0;
      check_count = 0;
      sc_reset();
      sc_prescale();
      sc_lock();
      sc_refuse();
      sc_stamp();
      sc_carry_init();
      sc_carry_master();
      end_sim();
   end
endmodule : tb
`default_nettype wire

/* inc/nts_defs.svh */
// Constants of the network time unit: codes, field values and reset values.
`ifndef NTS_DEFS_SVH
`define NTS_DEFS_SVH

// ----------------------------------------------------------------------------
// Counter and prescaler
// ----------------------------------------------------------------------------
`define NTS_TIME_W          16
`define NTS_PRE_W           13
`define NTS_PRE_BASE        13'h0020
`define NTS_PRE_ONE         13'h0001

// ----------------------------------------------------------------------------
// Lock qualification
// ----------------------------------------------------------------------------
`define NTS_LOCK_WINDOW     16'h0002
`define NTS_LOCK_COUNT      2'h3
`define NTS_GOOD_STEP       2'h1

// ----------------------------------------------------------------------------
// Configuration codes
// ----------------------------------------------------------------------------
`define NTS_TRIG_LATCH      4'h6
`define NTS_FLAG_UNLOCK     4'h4
`define NTS_FLAG_CARRY      4'h5
`define NTS_NO_MASTER       4'h0
`define NTS_MAX_ID_SMALL    4'h7
`define NTS_STYLE_RESET     1'b1
`define NTS_STATUS_RESET    1'b1

`endif

/* inc/nts_pkg.sv */
// Types shared by the network time unit modules.
`default_nettype none
package nts_pkg;

   // ----------------------------------------------------------------------------
   // Lock state of the local counter against the time master.
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      NTS_UNLOCKED = 2'b01,
      NTS_LOCKED   = 2'b10
   } nts_lock_e;

   // A network time value.
   typedef logic [15:0] nts_time_t;

endpackage : nts_pkg
`default_nettype wire

/* rtl/nts_prescaler.sv */
// Prescaler that turns the system clock into network time ticks.
`timescale 1ns/1ps
`default_nettype none
`include "nts_defs.svh"
module nts_prescaler #(
   parameter int SEL_W = 3
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [SEL_W-1:0] time_prescale_sel,
   input  wire logic             clear,
   output var  logic             tick
);
   // ----------------------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------------------
   logic [`NTS_PRE_W-1:0] ratio;    // Clocks per tick, 32 shifted by the code.
   logic [`NTS_PRE_W-1:0] count;    // Clocks since the last tick.

   // Ratio runs from 32 for code 0 up to 4096 for code 7.
   assign ratio = `NTS_PRE_BASE << time_prescale_sel;

   // A clear restarts the phase so a resync lines the tick up with the master.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (clear) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count >= ratio - `NTS_PRE_ONE) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + `NTS_PRE_ONE;
         tick  <= 1'b0;
      end
   end

   // Ticks are never closer than nine clocks apart.
   property p_tick_spacing;
      @(posedge core_clk) disable iff (rst)
      tick |=> !tick [*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");
endmodule : nts_prescaler
`default_nettype wire

/* rtl/nts_sync2.sv */
// Two-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module nts_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   // ----------------------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------------------
   logic [WIDTH-1:0] stage1;   // First stage, read only by the second stage.

   // Both stages reset high so an idle active-low pin makes no edge at release.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage1   <= '1;
         sync_out <= '1;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : nts_sync2
`default_nettype wire

/* rtl/nts_time_unit.sv */
// Network time unit: local time counter, master lock, stamping and carry output.
//
// Behaviour
// - Keep 16-bit time, carried in last bytes
// - Master packet time syncs; others are stamps
// - Transmit stamp is send time or trigger latch
// - Tick period is clock times 32 shifted
// - Resync on each master packet, if id in range
// - Lock shown on flag pin and status
// - Carry pin active only when both configured
// - Carry style: 0 pulse, 1 clock default
// - Carry selection n routes counter bit n
// - Carry pin high until start condition
// - Start on setting packet or master packet
// - Lock after three good values, else unlock
// - Master reads unlocked zero; status sticky
`timescale 1ns/1ps
`default_nettype none
`include "nts_defs.svh"
module nts_time_unit
   import nts_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  own_node_id,
   input  wire logic [3:0]  master_node_id,
   input  wire logic [2:0]  time_prescale_sel,
   input  wire logic        page_size_sel,
   input  wire logic [3:0]  transmit_trigger_sel,
   input  wire logic [3:0]  flag_output_select,
   input  wire logic        flag_sel_configured,
   input  wire logic [3:0]  carry_bit_sel,
   input  wire logic        carry_sel_configured,
   input  wire logic        carry_style_wr,
   input  wire logic        carry_style_val,
   input  wire logic        rx_valid,
   input  wire logic [3:0]  rx_src_id,
   input  wire logic [15:0] rx_time,
   input  wire logic        rx_init_setting,
   input  wire logic        tx_stamp_req,
   input  wire logic        ext_trig_n,
   input  wire logic        status_clear,
   output var  logic [15:0] network_time,
   output var  logic [15:0] tx_stamp,
   output var  logic        tx_stamp_valid,
   output var  logic [15:0] rx_stamp,
   output var  logic        rx_stamp_valid,
   output var  logic        time_unlocked,
   output var  logic        time_unlocked_flag,
   output var  logic        carry_output_style,
   output var  logic        time_carry_out_n
);
   // ----------------------------------------------------------------------------
   // Decoded configuration and packet classes
   // ----------------------------------------------------------------------------
   logic        own_master;     // This node is the time master.
   logic        no_master;      // No master is named.
   logic        master_id_ok;   // Master id lies within the page-size limit.
   logic        from_master;    // Received packet came from the master.
   logic        resync;         // Received packet resynchronises the counter.
   logic        tick;           // One-cycle prescaled tick.
   logic        trig_sync;      // Synchronised external trigger pin.
   logic        trig_prev;      // Trigger level one cycle earlier.
   nts_time_t   trig_latch;     // Counter value held at the last trigger edge.
   nts_time_t   diff;           // Master time minus local time, modulo 2^16.
   logic        diff_ok;        // Difference lies within two ticks either way.
   logic [1:0]  good_cnt;       // Consecutive good master values, saturating.
   nts_lock_e   lock_state;     // Lock state against the master.
   logic        carry_run;      // Carry output has met its start condition.
   logic        carry_enable;   // Flag selection set to carry and both selections configured.
   logic        carry_bit;      // Counter bit routed to the carry output.
   logic        carry_bit_prev; // Routed bit one cycle earlier.

   assign own_master   = (master_node_id == own_node_id);
   assign no_master    = (master_node_id == `NTS_NO_MASTER);
   // A wrong master id is a host slip; such a node is treated as unsynchronised.
   assign master_id_ok = page_size_sel || (master_node_id <= `NTS_MAX_ID_SMALL);
   assign from_master  = rx_valid && (rx_src_id == master_node_id);
   // Any destination counts: unicast, broadcast or a packet for another node.
   assign resync       = from_master && !own_master && !no_master && master_id_ok;
   assign diff         = rx_time - network_time;
   assign diff_ok      = (diff <= `NTS_LOCK_WINDOW) || ((-diff) <= `NTS_LOCK_WINDOW);
   assign carry_enable = flag_sel_configured && carry_sel_configured
                         && (flag_output_select == `NTS_FLAG_CARRY);
   assign carry_bit    = network_time[carry_bit_sel];

   // ----------------------------------------------------------------------------
   // Prescaler and trigger synchroniser
   // ----------------------------------------------------------------------------
   // The prescaler restarts on resync so the local tick phase follows the master.
   nts_prescaler #(
      .SEL_W (3)
   ) u_prescaler (
      .core_clk          (core_clk),
      .rst               (rst),
      .time_prescale_sel (time_prescale_sel),
      .clear             (resync),
      .tick              (tick)
   );

   // The trigger pin is asynchronous and must pass two flops first.
   nts_sync2 #(
      .WIDTH (1)
   ) u_trig_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (ext_trig_n),
      .sync_out (trig_sync)
   );

   // ----------------------------------------------------------------------------
   // Local time counter
   // ----------------------------------------------------------------------------
   // A resync loads the master's value; otherwise each tick adds one and wraps.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         network_time <= '0;
      end else if (resync) begin
         network_time <= rx_time;
      end else if (tick) begin
         network_time <= network_time + 16'h0001;
      end
   end

   // ----------------------------------------------------------------------------
   // Trigger latch and time stamps
   // ----------------------------------------------------------------------------
   // The counter is caught on the falling edge of the active-low trigger.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trig_prev  <= 1'b1;
         trig_latch <= '0;
      end else begin
         trig_prev <= trig_sync;
         if (trig_prev && !trig_sync) begin
            trig_latch <= network_time;
         end
      end
   end

   // Outgoing stamp: send time, or the latched trigger time in latch mode.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_stamp       <= '0;
         tx_stamp_valid <= 1'b0;
      end else begin
         tx_stamp_valid <= tx_stamp_req;
         if (tx_stamp_req) begin
            if (transmit_trigger_sel == `NTS_TRIG_LATCH) begin
               tx_stamp <= trig_latch;
            end else begin
               tx_stamp <= network_time;
            end
         end
      end
   end

   // Packets from other nodes carry a receive stamp, passed on untouched.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_stamp       <= '0;
         rx_stamp_valid <= 1'b0;
      end else begin
         rx_stamp_valid <= rx_valid && !from_master;
         if (rx_valid && !from_master) begin
            rx_stamp <= rx_time;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Lock qualification
   // ----------------------------------------------------------------------------
   // Three good master values in a row lock; a single bad one unlocks at once.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         good_cnt   <= '0;
         lock_state <= NTS_UNLOCKED;
      end else if (resync) begin
         if (!diff_ok) begin
            good_cnt   <= '0;
            lock_state <= NTS_UNLOCKED;
         end else begin
            unique case (lock_state)
               NTS_UNLOCKED: begin
                  if (good_cnt == `NTS_LOCK_COUNT - `NTS_GOOD_STEP) begin
                     lock_state <= NTS_LOCKED;
                  end
                  good_cnt <= good_cnt + `NTS_GOOD_STEP;
               end
               NTS_LOCKED: begin
                  good_cnt <= `NTS_LOCK_COUNT;
               end
               default: begin
                  lock_state <= NTS_UNLOCKED;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Unlock status bit and flag pin
   // ----------------------------------------------------------------------------
   // The status is sticky: an unlock in the clearing cycle still sets it.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         time_unlocked <= `NTS_STATUS_RESET;
      end else if (own_master) begin
         time_unlocked <= 1'b0;
      end else if (lock_state != NTS_LOCKED) begin
         time_unlocked <= 1'b1;
      end else if (status_clear) begin
         time_unlocked <= 1'b0;
      end
   end

   // The pin follows the lock state one clock later, when selected as the flag.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         time_unlocked_flag <= 1'b0;
      end else begin
         time_unlocked_flag <= (flag_output_select == `NTS_FLAG_UNLOCK) && !own_master
                               && (lock_state != NTS_LOCKED);
      end
   end

   // ----------------------------------------------------------------------------
   // Carry output
   // ----------------------------------------------------------------------------
   // Style is a configuration bit; clock style after reset.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         carry_output_style <= `NTS_STYLE_RESET;
      end else if (carry_style_wr) begin
         carry_output_style <= carry_style_val;
      end
   end

   // Start condition depends on whether another node is the master.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         carry_run <= 1'b0;
      end else if (own_master || no_master) begin
         if (rx_init_setting) begin
            carry_run <= 1'b1;
         end
      end else if (from_master) begin
         carry_run <= 1'b1;
      end
   end

   // Clock style drives the inverse of the bit; pulse style drops low for one clock as the bit
   // falls, so one pulse marks each full period of the selected bit.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         carry_bit_prev   <= 1'b0;
         time_carry_out_n <= 1'b1;
      end else begin
         carry_bit_prev <= carry_bit;
         if (!(carry_run && carry_enable)) begin
            time_carry_out_n <= 1'b1;
         end else if (carry_output_style) begin
            time_carry_out_n <= !carry_bit;
         end else begin
            time_carry_out_n <= !(carry_bit_prev && !carry_bit);
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   property p_tick_inc;
      @(posedge core_clk) disable iff (rst)
      tick && !resync |=> network_time == $past(network_time) + 16'h0001;
   endproperty
   a_tick_inc: assert property (p_tick_inc) else $error("counter did not step");

   property p_resync_load;
      @(posedge core_clk) disable iff (rst)
      resync |=> network_time == $past(rx_time);
   endproperty
   a_resync_load: assert property (p_resync_load) else $error("resync not loaded");

   property p_stamp_now;
      @(posedge core_clk) disable iff (rst)
      tx_stamp_req && transmit_trigger_sel != `NTS_TRIG_LATCH |=> tx_stamp_valid && tx_stamp == $past(network_time);
   endproperty
   a_stamp_now: assert property (p_stamp_now) else $error("send stamp wrong");

   property p_stamp_latch;
      @(posedge core_clk) disable iff (rst)
      tx_stamp_req && transmit_trigger_sel == `NTS_TRIG_LATCH |=> tx_stamp == $past(trig_latch);
   endproperty
   a_stamp_latch: assert property (p_stamp_latch) else $error("latch stamp wrong");

   property p_master_clear;
      @(posedge core_clk) disable iff (rst)
      own_master |=> !time_unlocked && !time_unlocked_flag;
   endproperty
   a_master_clear: assert property (p_master_clear) else $error("master shows unlock");

   property p_lock_three;
      @(posedge core_clk) disable iff (rst)
      lock_state == NTS_UNLOCKED ##1 lock_state == NTS_LOCKED |-> $past(resync && diff_ok && good_cnt == 2'h2);
   endproperty
   a_lock_three: assert property (p_lock_three) else $error("lock too early");

   property p_unlock_bad;
      @(posedge core_clk) disable iff (rst)
      resync && !diff_ok |=> lock_state == NTS_UNLOCKED ##1 time_unlocked;
   endproperty
   a_unlock_bad: assert property (p_unlock_bad) else $error("bad value kept lock");

   property p_carry_idle;
      @(posedge core_clk) disable iff (rst)
      !(carry_run && carry_enable) |=> time_carry_out_n;
   endproperty
   a_carry_idle: assert property (p_carry_idle) else $error("carry driven early");

   property p_carry_clock;
      @(posedge core_clk) disable iff (rst)
      carry_run && carry_enable && carry_output_style |=> time_carry_out_n == !$past(carry_bit);
   endproperty
   a_carry_clock: assert property (p_carry_clock) else $error("carry clock wrong");
endmodule : nts_time_unit
`default_nettype wire
